// ==== verification/cct_checker.sv ====
`timescale 1ns/10ps
// ------------------------------------------------------------
// interface checker for the timer pair
// ------------------------------------------------------------
module cct_checker (
    input wire logic clk,
    input wire logic rst,
    input wire logic [4:0] reg_num,
    input wire logic [2:0] reg_sel,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [31:0] wr_data,
    input wire logic [31:0] rd_data,
    input wire logic rd_valid,
    input wire logic timer_irq_out,
    input wire logic hwr_req,
    input wire logic [4:0] hwr_idx,
    input wire logic hwr_ack,
    input wire logic hwr_rsv_exc
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    logic cmp_wr;
    logic mask_wr;
    logic mask_bit;
    logic [31:0] cmp_r;
    logic [31:0] cmp_nxt;
    logic [31:0] mask_r;
    logic [31:0] mask_nxt;

    // decode of writes to the shadowed registers
    assign cmp_wr = wr_en && reg_num == cct_pkg::NUM_COMPARE && reg_sel == cct_pkg::SEL_0;
    assign mask_wr = wr_en && reg_num == cct_pkg::NUM_HWMASK && reg_sel == cct_pkg::SEL_0;
    assign mask_bit = mask_r[hwr_idx];

    // shadow copies of compare and access mask
    always_comb begin
        cmp_nxt = cmp_wr ? wr_data : cmp_r;
        mask_nxt = mask_wr ? wr_data : mask_r;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cmp_r <= 32'h0000_0000;
            mask_r <= 32'h0000_0000;
        end else begin
            cmp_r <= cmp_nxt;
            mask_r <= mask_nxt;
        end
    end

    // read path timing and contents
    AST_RD_LAT: assert property (rd_en |=> rd_valid)
        else $error("read strobe not answered next cycle");
    AST_RD_IDLE: assert property (!rd_en |=> !rd_valid && $stable(rd_data))
        else $error("read answer without strobe");
    AST_RD_SRC: assert property (rd_valid |-> $past(rd_en))
        else $error("read answer without earlier strobe");
    AST_CMP_VAL: assert property ((rd_en && reg_num == cct_pkg::NUM_COMPARE && reg_sel == 3'h0) |=> rd_data == $past(cmp_r))
        else $error("compare read differs from last write");
    AST_MASK_RD: assert property ((rd_en && reg_num == cct_pkg::NUM_HWMASK && reg_sel == 3'h0) |=> rd_data == $past(mask_r))
        else $error("mask read differs from last write");
    // timer interrupt stays until compare is written
    AST_IRQ_HOLD: assert property (timer_irq_out && !cmp_wr |=> timer_irq_out)
        else $error("timer interrupt dropped without compare write");
    // hardware register access check
    AST_HWR_LAT: assert property (hwr_req |=> hwr_ack && (hwr_rsv_exc == !$past(mask_bit)))
        else $error("access check answer wrong");
    AST_HWR_IDLE: assert property (!hwr_req |=> !hwr_ack)
        else $error("access answer without request");
    AST_EXC_ACK: assert property (hwr_rsv_exc |-> hwr_ack)
        else $error("reserved exception outside answer");
endmodule : cct_checker

// ==== verification/cp0_count_compare_timer_test.sv ====
`timescale 1ns/10ps
module cp0_count_compare_timer_test;
    // ------------------------------------------------------------
    // signals and instances
    // ------------------------------------------------------------
    logic clk;
    logic rst;
    logic boot_start, cmd_valid, cmd_write, dbg, ld_err, st_err, hreq;
    logic cmd_ready, resp_valid, boot_busy, hwr_done, hwr_exc, irq;
    logic [4:0] cmd_num;
    logic [4:0] hidx;
    logic [31:0] cmd_wdata, vaddr, resp_data, count_value, rdv, c0, d;
    logic [5:0] irq_lines, irq_pending;
    logic [7:0] wq[$];
    logic [7:0] bo[6] = '{8'h09, 8'h0b, 8'h2f, 8'h2c, 8'h0d, 8'h0c};
    int fail_count = 0;
    int n_checks = 0;
    int seed = 32'hae2127e3;
    int i;
    int k;

    cct_if bus ();
    cct_dev i_cct_dev (.clk(clk), .rst(rst), .bus(bus), .timer_irq_out(irq),
        .count_value(count_value));
    cct_core i_cct_core (.clk(clk), .rst(rst), .bus(bus), .boot_start(boot_start),
        .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_num(cmd_num), .cmd_sel(3'h0),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .resp_valid(resp_valid),
        .resp_data(resp_data), .boot_busy(boot_busy), .debug_mode_in(dbg), .ld_err_in(ld_err),
        .st_err_in(st_err), .err_vaddr_in(vaddr), .hwr_req_in(hreq), .hwr_idx_in(hidx),
        .hwr_done(hwr_done), .hwr_exc(hwr_exc), .irq_lines_in(irq_lines),
        .irq_pending(irq_pending));
    cct_checker i_cct_checker (.clk(clk), .rst(rst), .reg_num(bus.reg_num),
        .reg_sel(bus.reg_sel), .wr_en(bus.wr_en), .rd_en(bus.rd_en), .wr_data(bus.wr_data),
        .rd_data(bus.rd_data), .rd_valid(bus.rd_valid), .timer_irq_out(bus.timer_irq_out),
        .hwr_req(bus.hwr_req), .hwr_idx(bus.hwr_idx), .hwr_ack(bus.hwr_ack),
        .hwr_rsv_exc(bus.hwr_rsv_exc));

    // ------------------------------------------------------------
    // clock, write monitor and helpers
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // record {select, number} of every register write
    always @(posedge clk) begin
        if (bus.wr_en === 1'b1) wq.push_back({bus.reg_sel, bus.reg_num});
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test

    // a used-up wait counts as a mismatch
    task automatic bound(input int lim);
        if (i >= lim) begin
            fail_count++;
            stop_test();
        end
    endtask : bound

    // one user access; a read leaves its answer in rdv
    task automatic cmd(input logic w, input logic [4:0] n, input logic [31:0] wd);
        for (i = 0; i < 40 && cmd_ready !== 1'b1; i++) @(negedge clk);
        bound(40);
        cmd_valid = 1'b1;
        cmd_write = w;
        cmd_num = n;
        cmd_wdata = wd;
        @(negedge clk);
        cmd_valid = 1'b0;
        repeat (2) @(negedge clk);
        for (i = 0; i < 8 && !w && resp_valid !== 1'b1; i++) @(negedge clk);
        if (!w) bound(8);
        rdv = resp_data;
    endtask : cmd

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {boot_start, cmd_valid, cmd_write, dbg, ld_err, st_err, hreq} = 7'h00;
        {cmd_num, hidx, cmd_wdata, vaddr, irq_lines} = 80'h0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        // counting rate, write, disable and debug gating
        cmd(1'b1, cct_pkg::NUM_COUNT, 32'h0000_1000);
        c0 = count_value;
        check({31'h0, (c0 - 32'h0000_1000) < 2}, 32'h1);
        repeat (20) @(negedge clk);
        check(count_value - c0, 32'h0000_000a);
        cmd(1'b1, cct_pkg::NUM_CAUSE, 32'h0800_0000);
        c0 = count_value;
        repeat (20) @(negedge clk);
        check(count_value, c0);
        dbg = 1'b1;
        cmd(1'b1, cct_pkg::NUM_CAUSE, 32'h0000_0000);
        c0 = count_value;
        repeat (20) @(negedge clk);
        check(count_value, c0);
        cmd(1'b1, cct_pkg::NUM_DEBUG, 32'h0200_0000);
        c0 = count_value;
        repeat (20) @(negedge clk);
        check(count_value - c0, 32'h0000_000a);
        cmd(1'b0, cct_pkg::NUM_DEBUG, 32'h0);
        check(rdv, 32'h4200_0000);
        dbg = 1'b0;
        $display("test count done");
        // match, hold and clear of the timer interrupt, count stopped
        cmd(1'b1, cct_pkg::NUM_CAUSE, 32'h0800_0000);
        cmd(1'b1, cct_pkg::NUM_COUNT, 32'h0000_0064);
        cmd(1'b1, cct_pkg::NUM_COMPARE, 32'h0000_0069);
        check({31'h0, irq}, 32'h0);
        cmd(1'b1, cct_pkg::NUM_COUNT, 32'h0000_0069);
        check({31'h0, irq}, 32'h1);
        irq_lines = 6'($random(seed));
        cmd(1'b1, cct_pkg::NUM_COUNT, 32'h0000_00c8);
        check({31'h0, irq}, 32'h1);
        check({26'h0, irq_pending}, {26'h0, irq_lines | 6'h01});
        cmd(1'b1, cct_pkg::NUM_COMPARE, 32'h0000_012c);
        check({31'h0, irq}, 32'h0);
        $display("test timer done");
        // address error capture, load then store
        for (k = 0; k < 2; k++) begin
            vaddr = $random(seed);
            ld_err = (k == 0);
            st_err = (k == 1);
            @(negedge clk);
            {ld_err, st_err} = 2'b00;
            cmd(1'b1, cct_pkg::NUM_BADVA, ~vaddr);
            cmd(1'b0, cct_pkg::NUM_BADVA, 32'h0);
            check(rdv, vaddr);
            cmd(1'b0, cct_pkg::NUM_CAUSE, 32'h0);
            d = {27'h0, k ? cct_pkg::EXC_STORE_ADDR : cct_pkg::EXC_LOAD_ADDR};
            check({27'h0, rdv[6:2]}, d);
        end
        cmd(1'b1, cct_pkg::NUM_CAUSE, 32'hffff_ffff);
        cmd(1'b0, cct_pkg::NUM_CAUSE, 32'h0);
        check(rdv, 32'h0880_0300 | {25'h0, cct_pkg::EXC_STORE_ADDR, 2'b00});
        $display("test capture done");
        // random read-back, unmapped place and access mask
        for (k = 0; k < 4; k++) begin
            d = $random(seed);
            cmd(1'b1, cct_pkg::NUM_COMPARE, d);
            cmd(1'b0, cct_pkg::NUM_COMPARE, 32'h0);
            check(rdv, d);
        end
        cmd(1'b0, 5'h1f, 32'h0);
        check(rdv, 32'h0);
        d = $random(seed);
        cmd(1'b1, cct_pkg::NUM_HWMASK, d);
        for (k = 0; k < 32; k++) begin
            hidx = 5'(k);
            hreq = 1'b1;
            @(negedge clk);
            hreq = 1'b0;
            for (i = 0; i < 8 && hwr_done !== 1'b1; i++) @(negedge clk);
            bound(8);
            check({31'h0, hwr_exc}, {31'h0, !d[k]});
        end
        $display("test mask done");
        // start-up sequence order and values
        d = $random(seed);
        cmd(1'b1, cct_pkg::NUM_STATUS, d);
        wq.delete();
        boot_start = 1'b1;
        @(negedge clk);
        boot_start = 1'b0;
        for (i = 0; i < 30 && boot_busy !== 1'b0; i++) @(negedge clk);
        bound(30);
        @(negedge clk);
        check(wq.size(), 32'h6);
        for (k = 0; k < 6; k++) check({24'h0, wq[k]}, {24'h0, bo[k]});
        cmd(1'b0, cct_pkg::NUM_COUNT, 32'h0);
        check(rdv, cct_pkg::COUNT_INIT);
        cmd(1'b0, cct_pkg::NUM_COMPARE, 32'h0);
        check(rdv, cct_pkg::COMPARE_INIT);
        cmd(1'b0, cct_pkg::NUM_STATUS, 32'h0);
        check(rdv, d & 32'h0058_0000);
        cmd(1'b0, cct_pkg::NUM_CAUSE, 32'h0);
        check(rdv & 32'h0880_0300, 32'h0880_0000);
        $display("test start-up done");
        stop_test();
    end
endmodule : cp0_count_compare_timer_test

// ==== verilog/cct_core.sv ====
`timescale 1ns/10ps
module cct_core #(
    parameter int unsigned TIMER_LINE = 0,
    parameter logic [31:0] EBASE_INIT = 32'h9fc0_1000,
    parameter logic [4:0] VSPACE_INIT = 5'h01
) (
    input wire logic clk,
    input wire logic rst,
    cct_if.core bus,
    input wire logic boot_start,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [4:0] cmd_num,
    input wire logic [2:0] cmd_sel,
    input wire logic [31:0] cmd_wdata,
    output logic cmd_ready,
    output logic resp_valid,
    output logic [31:0] resp_data,
    output logic boot_busy,
    input wire logic debug_mode_in,
    input wire logic ld_err_in,
    input wire logic st_err_in,
    input wire logic [31:0] err_vaddr_in,
    input wire logic hwr_req_in,
    input wire logic [4:0] hwr_idx_in,
    output logic hwr_done,
    output logic hwr_exc,
    input wire logic [cct_pkg::NUM_IRQ_LINES-1:0] irq_lines_in,
    output logic [cct_pkg::NUM_IRQ_LINES-1:0] irq_pending
);
    typedef enum {
        ST_IDLE, ST_COUNT, ST_COMPARE, ST_EBASE, ST_INTERRUPT_CONTROL_REG,
        ST_RD_CAUSE, ST_GAP_CAUSE, ST_WR_CAUSE,
        ST_RD_STATUS, ST_GAP_STATUS, ST_WR_STATUS
    } cct_boot_t;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    cct_boot_t st_r, st_nxt;
    logic [4:0] num_r, num_nxt;
    logic [2:0] sel_r, sel_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic wr_r, wr_nxt;
    logic rd_r, rd_nxt;
    logic tag_r, tag_nxt, tag2_r;
    logic [31:0] resp_data_r, resp_data_nxt;
    logic resp_valid_r, resp_valid_nxt;
    logic [31:0] keep;
    logic [cct_pkg::NUM_IRQ_LINES-1:0] irq_nxt, irq_r;

    // boot sequencer and access mux
    always_comb begin
        st_nxt = st_r;
        num_nxt = cct_pkg::NUM_COUNT;
        sel_nxt = cct_pkg::SEL_0;
        wdata_nxt = cct_pkg::RST_WORD;
        wr_nxt = 1'b0;
        rd_nxt = 1'b0;
        tag_nxt = 1'b0;
        keep = cct_pkg::RST_WORD;
        case (st_r)
            ST_IDLE: begin
                if (boot_start) begin
                    st_nxt = ST_COUNT;
                end else if (cmd_valid) begin
                    num_nxt = cmd_num;
                    sel_nxt = cmd_sel;
                    wdata_nxt = cmd_wdata;
                    wr_nxt = cmd_write;
                    rd_nxt = !cmd_write;
                    tag_nxt = !cmd_write;
                end
            end
            ST_COUNT: begin
                wdata_nxt = cct_pkg::COUNT_INIT;
                wr_nxt = 1'b1;
                st_nxt = ST_COMPARE;
            end
            ST_COMPARE: begin
                num_nxt = cct_pkg::NUM_COMPARE;
                wdata_nxt = cct_pkg::COMPARE_INIT;
                wr_nxt = 1'b1;
                st_nxt = ST_EBASE;
            end
            ST_EBASE: begin
                num_nxt = cct_pkg::NUM_EBASE;
                sel_nxt = cct_pkg::SEL_1;
                wdata_nxt = EBASE_INIT;
                wr_nxt = 1'b1;
                st_nxt = ST_INTERRUPT_CONTROL_REG;
            end
            ST_INTERRUPT_CONTROL_REG: begin
                num_nxt = cct_pkg::NUM_STATUS;
                sel_nxt = cct_pkg::SEL_1;
                wdata_nxt = cct_pkg::INTERRUPT_CONTROL_REG_ONES;
                wdata_nxt[cct_pkg::INTERRUPT_CONTROL_REG_VS_LO +: 5] = VSPACE_INIT;
                wr_nxt = 1'b1;
                st_nxt = ST_RD_CAUSE;
            end
            ST_RD_CAUSE: begin
                num_nxt = cct_pkg::NUM_CAUSE;
                rd_nxt = 1'b1;
                st_nxt = ST_GAP_CAUSE;
            end
            ST_GAP_CAUSE: begin
                st_nxt = ST_WR_CAUSE;
            end
            ST_WR_CAUSE: begin
                // count-disable kept, vector select on, soft requests off
                keep[cct_pkg::CAUSE_DC] = bus.rd_data[cct_pkg::CAUSE_DC];
                keep[cct_pkg::CAUSE_IV] = 1'b1;
                num_nxt = cct_pkg::NUM_CAUSE;
                wdata_nxt = keep;
                wr_nxt = 1'b1;
                st_nxt = ST_RD_STATUS;
            end
            ST_RD_STATUS: begin
                num_nxt = cct_pkg::NUM_STATUS;
                rd_nxt = 1'b1;
                st_nxt = ST_GAP_STATUS;
            end
            ST_GAP_STATUS: begin
                st_nxt = ST_WR_STATUS;
            end
            ST_WR_STATUS: begin
                // only boot vector and reset reason flags survive
                keep[cct_pkg::STATUS_BEV] = bus.rd_data[cct_pkg::STATUS_BEV];
                keep[cct_pkg::STATUS_SR] = bus.rd_data[cct_pkg::STATUS_SR];
                keep[cct_pkg::STATUS_NMI] = bus.rd_data[cct_pkg::STATUS_NMI];
                num_nxt = cct_pkg::NUM_STATUS;
                wdata_nxt = keep;
                wr_nxt = 1'b1;
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
        resp_valid_nxt = bus.rd_valid && tag2_r;
        resp_data_nxt = (bus.rd_valid && tag2_r) ? bus.rd_data : resp_data_r;
        // timer output fed back onto one interrupt line
        irq_nxt = irq_lines_in;
        irq_nxt[TIMER_LINE] = irq_lines_in[TIMER_LINE] | bus.timer_irq_out;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic dbg_r, lde_r, ste_r, hreq_r, hdone_r, hexc_r;
    logic [31:0] eva_r;
    logic [4:0] hidx_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_r <= ST_IDLE;
            num_r <= 5'h00;
            sel_r <= 3'h0;
            wdata_r <= cct_pkg::RST_WORD;
            wr_r <= 1'b0;
            rd_r <= 1'b0;
            tag_r <= 1'b0;
            tag2_r <= 1'b0;
            resp_data_r <= cct_pkg::RST_WORD;
            resp_valid_r <= 1'b0;
            irq_r <= '0;
            dbg_r <= 1'b0;
            lde_r <= 1'b0;
            ste_r <= 1'b0;
            eva_r <= cct_pkg::RST_WORD;
            hreq_r <= 1'b0;
            hidx_r <= 5'h00;
            hdone_r <= 1'b0;
            hexc_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            num_r <= num_nxt;
            sel_r <= sel_nxt;
            wdata_r <= wdata_nxt;
            wr_r <= wr_nxt;
            rd_r <= rd_nxt;
            tag_r <= tag_nxt;
            tag2_r <= tag_r;
            resp_data_r <= resp_data_nxt;
            resp_valid_r <= resp_valid_nxt;
            irq_r <= irq_nxt;
            dbg_r <= debug_mode_in;
            lde_r <= ld_err_in;
            ste_r <= st_err_in;
            eva_r <= err_vaddr_in;
            hreq_r <= hwr_req_in;
            hidx_r <= hwr_idx_in;
            hdone_r <= bus.hwr_ack;
            hexc_r <= bus.hwr_rsv_exc;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign bus.reg_num = num_r;
    assign bus.reg_sel = sel_r;
    assign bus.wr_data = wdata_r;
    assign bus.wr_en = wr_r;
    assign bus.rd_en = rd_r;
    assign bus.debug_mode = dbg_r;
    assign bus.load_address_error = lde_r;
    assign bus.store_address_error = ste_r;
    assign bus.err_vaddr = eva_r;
    assign bus.hwr_req = hreq_r;
    assign bus.hwr_idx = hidx_r;
    assign cmd_ready = (st_r == ST_IDLE) && !boot_start;
    assign boot_busy = (st_r != ST_IDLE);
    assign resp_valid = resp_valid_r;
    assign resp_data = resp_data_r;
    assign hwr_done = hdone_r;
    assign hwr_exc = hexc_r;
    assign irq_pending = irq_r;
endmodule : cct_core

// ==== verilog/cct_dev.sv ====
`timescale 1ns/10ps
module cct_dev (
    input wire logic clk,
    input wire logic rst,
    cct_if.dev bus,
    output logic timer_irq_out,
    output logic [31:0] count_value
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // visible words
    logic [31:0] count_r, count_nxt;
    logic [31:0] compare_r, compare_nxt;
    logic [31:0] hwmask_r, hwmask_nxt;
    logic [31:0] badva_r, badva_nxt;
    logic [31:0] status_r, status_nxt;

    // read answer
    logic [31:0] rdata_r, rdata_nxt;

    // cause, debug fields
    logic [4:0] exc_r, exc_nxt;
    logic [1:0] swirq_r, swirq_nxt;
    logic dc_r, dc_nxt;
    logic iv_r, iv_nxt;
    logic debug_mode_count_enable_r, debug_mode_count_enable_nxt;

    // pacing, flags
    logic phase_r, phase_nxt;
    logic pend_r, pend_nxt;
    logic rvalid_r, rvalid_nxt;
    logic hack_r, hack_nxt;
    logic hexc_r, hexc_nxt;

    // helpers
    logic run;
    logic match;
    logic cmp_wr;

    // register select decode
    function automatic logic hit(input logic [4:0] n, input logic [2:0] s,
                                 input logic [4:0] wn, input logic [2:0] ws);
        hit = (n == wn) && (s == ws);
    endfunction : hit

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb begin
        // hold by default
        count_nxt = count_r;
        compare_nxt = compare_r;
        hwmask_nxt = hwmask_r;
        badva_nxt = badva_r;
        status_nxt = status_r;
        exc_nxt = exc_r;
        swirq_nxt = swirq_r;
        dc_nxt = dc_r;
        iv_nxt = iv_r;
        debug_mode_count_enable_nxt = debug_mode_count_enable_r;
        rdata_nxt = cct_pkg::RST_WORD;

        // enable depends on control bits and the debug mode input, never on the pipeline
        run = !dc_r && (!bus.debug_mode || debug_mode_count_enable_r);
        phase_nxt = run ? ~phase_r : phase_r;
        if (run && phase_r) begin
            count_nxt = count_r + 32'h0000_0001;
        end

        // compare write, match
        cmp_wr = bus.wr_en && hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_COMPARE, cct_pkg::SEL_0);
        match = (count_r == compare_r);

        // set wins over the clearing compare write
        pend_nxt = match ? 1'b1 : (cmp_wr ? 1'b0 : pend_r);

        // writes
        if (bus.wr_en) begin
            if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_COUNT, cct_pkg::SEL_0)) begin
                count_nxt = bus.wr_data;
            end else if (cmp_wr) begin
                compare_nxt = bus.wr_data;
            end else if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_HWMASK, cct_pkg::SEL_0)) begin
                hwmask_nxt = bus.wr_data;
            end else if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_STATUS, cct_pkg::SEL_0)) begin
                status_nxt = bus.wr_data;
            end else if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_CAUSE, cct_pkg::SEL_0)) begin
                dc_nxt = bus.wr_data[cct_pkg::CAUSE_DC];
                iv_nxt = bus.wr_data[cct_pkg::CAUSE_IV];
                swirq_nxt = bus.wr_data[cct_pkg::CAUSE_IP_LO +: 2];
            end else if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_DEBUG, cct_pkg::SEL_0)) begin
                debug_mode_count_enable_nxt = bus.wr_data[cct_pkg::DEBUG_DEBUG_MODE_COUNT_ENABLE];
            end
        end

        // address error capture, store reported over load
        if (bus.load_address_error || bus.store_address_error) begin
            badva_nxt = bus.err_vaddr;
            exc_nxt = bus.store_address_error ? cct_pkg::EXC_STORE_ADDR
                                              : cct_pkg::EXC_LOAD_ADDR;
        end

        // read mux, unmapped reads as zero
        if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_COUNT, cct_pkg::SEL_0)) begin
            rdata_nxt = count_r;
        end else if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_COMPARE, cct_pkg::SEL_0)) begin
            rdata_nxt = compare_r;
        end else if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_HWMASK, cct_pkg::SEL_0)) begin
            rdata_nxt = hwmask_r;
        end else if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_BADVA, cct_pkg::SEL_0)) begin
            rdata_nxt = badva_r;
        end else if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_STATUS, cct_pkg::SEL_0)) begin
            rdata_nxt = status_r;
        end else if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_CAUSE, cct_pkg::SEL_0)) begin
            rdata_nxt[cct_pkg::CAUSE_TI] = pend_r;
            rdata_nxt[cct_pkg::CAUSE_DC] = dc_r;
            rdata_nxt[cct_pkg::CAUSE_IV] = iv_r;
            rdata_nxt[cct_pkg::CAUSE_IP_LO +: 2] = swirq_r;
            rdata_nxt[cct_pkg::CAUSE_EXC_LO +: 5] = exc_r;
        end else if (hit(bus.reg_num, bus.reg_sel, cct_pkg::NUM_DEBUG, cct_pkg::SEL_0)) begin
            rdata_nxt[cct_pkg::DEBUG_DM] = bus.debug_mode;
            rdata_nxt[cct_pkg::DEBUG_DEBUG_MODE_COUNT_ENABLE] = debug_mode_count_enable_r;
        end

        // keep last answer
        if (!bus.rd_en) begin
            rdata_nxt = rdata_r;
        end
        // answer flag
        rvalid_nxt = bus.rd_en;

        // hardware register read gate
        hack_nxt = bus.hwr_req;
        hexc_nxt = bus.hwr_req && !hwmask_r[bus.hwr_idx];
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // flops, async clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // clear all
            count_r <= cct_pkg::RST_WORD;
            compare_r <= cct_pkg::RST_WORD;
            hwmask_r <= cct_pkg::RST_WORD;
            badva_r <= cct_pkg::RST_WORD;
            status_r <= cct_pkg::RST_WORD;
            rdata_r <= cct_pkg::RST_WORD;
            exc_r <= 5'h00;
            swirq_r <= 2'h0;
            dc_r <= 1'b0;
            iv_r <= 1'b0;
            debug_mode_count_enable_r <= 1'b0;
            phase_r <= 1'b0;
            pend_r <= 1'b0;
            rvalid_r <= 1'b0;
            hack_r <= 1'b0;
            hexc_r <= 1'b0;
        end else begin
            // load next
            count_r <= count_nxt;
            compare_r <= compare_nxt;
            hwmask_r <= hwmask_nxt;
            badva_r <= badva_nxt;
            status_r <= status_nxt;
            rdata_r <= rdata_nxt;
            exc_r <= exc_nxt;
            swirq_r <= swirq_nxt;
            dc_r <= dc_nxt;
            iv_r <= iv_nxt;
            debug_mode_count_enable_r <= debug_mode_count_enable_nxt;
            phase_r <= phase_nxt;
            pend_r <= pend_nxt;
            rvalid_r <= rvalid_nxt;
            hack_r <= hack_nxt;
            hexc_r <= hexc_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // bus side
    assign bus.rd_data = rdata_r;
    assign bus.rd_valid = rvalid_r;
    assign bus.timer_irq_out = pend_r;
    assign bus.hwr_ack = hack_r;
    assign bus.hwr_rsv_exc = hexc_r;

    // user side
    assign timer_irq_out = pend_r;
    assign count_value = count_r;
endmodule : cct_dev

// ==== verilog/cct_if.sv ====
`timescale 1ns/10ps
interface cct_if;
    logic [4:0] reg_num;
    logic [2:0] reg_sel;
    logic wr_en;
    logic rd_en;
    logic [31:0] wr_data;
    logic [31:0] rd_data;
    logic rd_valid;
    logic timer_irq_out;
    logic debug_mode;
    logic load_address_error;
    logic store_address_error;
    logic [31:0] err_vaddr;
    logic hwr_req;
    logic [4:0] hwr_idx;
    logic hwr_ack;
    logic hwr_rsv_exc;

    modport dev (
        input reg_num, reg_sel, wr_en, rd_en, wr_data, debug_mode,
        input load_address_error, store_address_error, err_vaddr, hwr_req, hwr_idx,
        output rd_data, rd_valid, timer_irq_out, hwr_ack, hwr_rsv_exc
    );
    modport core (
        output reg_num, reg_sel, wr_en, rd_en, wr_data, debug_mode,
        output load_address_error, store_address_error, err_vaddr, hwr_req, hwr_idx,
        input rd_data, rd_valid, timer_irq_out, hwr_ack, hwr_rsv_exc
    );
endinterface : cct_if

// ==== verilog/cct_pkg.sv ====
package cct_pkg;
    // ------------------------------------------------------------
    // register numbers and selects
    // ------------------------------------------------------------
    localparam logic [4:0] NUM_HWMASK = 5'h07;
    localparam logic [4:0] NUM_BADVA = 5'h08;
    localparam logic [4:0] NUM_COUNT = 5'h09;
    localparam logic [4:0] NUM_COMPARE = 5'h0b;
    localparam logic [4:0] NUM_STATUS = 5'h0c;
    localparam logic [4:0] NUM_CAUSE = 5'h0d;
    localparam logic [4:0] NUM_EBASE = 5'h0f;
    localparam logic [4:0] NUM_DEBUG = 5'h17;
    localparam logic [2:0] SEL_0 = 3'h0;
    localparam logic [2:0] SEL_1 = 3'h1;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned CAUSE_TI = 30;
    localparam int unsigned CAUSE_DC = 27;
    localparam int unsigned CAUSE_IV = 23;
    localparam int unsigned CAUSE_IP_LO = 8;
    localparam int unsigned CAUSE_EXC_LO = 2;
    localparam int unsigned DEBUG_DM = 30;
    localparam int unsigned DEBUG_DEBUG_MODE_COUNT_ENABLE = 25;
    localparam int unsigned STATUS_BEV = 22;
    localparam int unsigned STATUS_SR = 20;
    localparam int unsigned STATUS_NMI = 19;
    localparam int unsigned INTERRUPT_CONTROL_REG_VS_LO = 5;

    // ------------------------------------------------------------
    // codes, reset and start-up values, counts
    // ------------------------------------------------------------
    localparam logic [4:0] EXC_LOAD_ADDR = 5'h04;
    localparam logic [4:0] EXC_STORE_ADDR = 5'h05;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] COMPARE_INIT = 32'h0fff_ffff;
    localparam logic [31:0] COUNT_INIT = 32'h0000_0000;
    localparam logic [31:0] INTERRUPT_CONTROL_REG_ONES = 32'hffff_ffff;
    localparam int unsigned COUNT_DIV = 2;
    localparam int unsigned NUM_IRQ_LINES = 6;
endpackage : cct_pkg
